// [flash_cmd.sv]
// Serial flash command interpreter for addressing, bank, reset and status.
// Behaviour
// - Bank top bit set: 4-byte addresses, bank ignored.
// - 16h reads bank, 17h writes one byte.
// - Top bit clear: bank bits form A30..A24.
// - E9h leaves 4-byte mode, no write enable.
// - Reset only on 66h followed by 99h.
// - Reset pair accepted on one, two, four lines.
// - Non-volatile status write needs prior 06h.
// - 50h enables volatile status overriding non-volatile.
// - Dedicated 4-byte read ignores address mode.
// - Capability bits read zero under reset, then one when supported.
// - B7h enters 4-byte mode, no write enable.
`include "flash_cmd_defines.svh"

module flash_cmd (
   // Clock and reset
   input  wire logic        REF_CLK_IN,
   input  wire logic        NRST_IN,
   // Serial link
   input  wire logic        SPI_CS_N_IN,
   input  wire logic        SPI_SCK_IN,
   input  wire logic [3:0]  SPI_IO_IN,
   output logic      [3:0]  SPI_IO_OUT,
   output logic      [3:0]  SPI_IO_OE_OUT,
   // Interface width of the current operating mode
   input  wire logic [1:0]  LANE_MODE_IN,
   // Decoded address towards the array
   output logic      [31:0] ADDR_OUT,
   output logic             ADDR_STB_OUT,
   // Block state
   output logic      [7:0]  BANK_OUT,
   output logic      [7:0]  STATUS_OUT,
   output logic             STATUS_VOL_OUT,
   output logic             WEL_OUT,
   output logic             SOFT_RST_OUT,
   output logic      [7:0]  CAPS_OUT
);

   flash_cmd_pkg::pins_t  pins;
   flash_cmd_pkg::state_t state_ff, nxt_state;

   logic [7:0]  sh_ff, nxt_sh, out_ff, nxt_out, op_ff, nxt_op;
   logic [7:0]  data_ff, nxt_data, bank_ff, nxt_bank;
   logic [7:0]  stat_nv_ff, nxt_stat_nv, stat_vol_ff, nxt_stat_vol;
   logic [23:0] asr_ff, nxt_asr;
   logic [31:0] addr_ff, nxt_addr;
   logic [3:0]  cnt_ff, nxt_cnt, io_ff, nxt_io, oe_ff, nxt_oe, wid;
   logic [2:0]  abytes_ff, nxt_abytes;
   logic [1:0]  nb_ff, nxt_nb;
   logic        a4_ff, nxt_a4, wel_ff, nxt_wel, vwel_ff, nxt_vwel;
   logic        vact_ff, nxt_vact, rsten_ff, nxt_rsten;
   logic        stb_ff, nxt_stb, srst_ff, nxt_srst;
   logic        byte_done;
   logic [7:0]  shin, stat_act;

   pin_sampler u_pins (
      .clk_in   (REF_CLK_IN),
      .rst_n_in (NRST_IN),
      .cs_n_in  (SPI_CS_N_IN),
      .sck_in   (SPI_SCK_IN),
      .io_in    (SPI_IO_IN),
      .lanes_in (LANE_MODE_IN),
      .pins_out (pins)
   );

   // Bits moved per clock edge for the active interface width.
   function automatic logic [3:0] lane_width(input logic [1:0] l);
      unique case (l)
         `LANES_ONE:  lane_width = 4'h1;
         `LANES_TWO:  lane_width = 4'h2;
         default:     lane_width = 4'h4;
      endcase
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic [3:0] io,
                                          input logic [1:0] l);
      unique case (l)
         `LANES_ONE:  shift_in = {s[6:0], io[0]};
         `LANES_TWO:  shift_in = {s[5:0], io[1:0]};
         default:     shift_in = {s[3:0], io[3:0]};
      endcase
   endfunction

   // The volatile copy shadows the stored one once activated.
   assign stat_act = vact_ff ? stat_vol_ff : stat_nv_ff;

   always_comb begin
      nxt_state    = state_ff;
      nxt_sh       = sh_ff;
      nxt_out      = out_ff;
      nxt_op       = op_ff;
      nxt_data     = data_ff;
      nxt_bank     = bank_ff;
      nxt_stat_nv  = stat_nv_ff;
      nxt_stat_vol = stat_vol_ff;
      nxt_asr      = asr_ff;
      nxt_addr     = addr_ff;
      nxt_cnt      = cnt_ff;
      nxt_io       = io_ff;
      nxt_oe       = oe_ff;
      nxt_abytes   = abytes_ff;
      nxt_nb       = nb_ff;
      nxt_a4       = a4_ff;
      nxt_wel      = wel_ff;
      nxt_vwel     = vwel_ff;
      nxt_vact     = vact_ff;
      nxt_rsten    = rsten_ff;
      nxt_stb      = 1'b0;
      nxt_srst     = 1'b0;
      wid          = lane_width(pins.lanes);
      shin         = shift_in(sh_ff, pins.io, pins.lanes);
      byte_done    = (cnt_ff + wid) == 4'h8;
      if (pins.cs_n) begin
         nxt_state = flash_cmd_pkg::S_IDLE;
         nxt_oe    = 4'h0;
         nxt_cnt   = 4'h0;
         // Commands take effect only when the frame closes cleanly.
         if (pins.cs_rise && state_ff != flash_cmd_pkg::S_IDLE) begin
            nxt_rsten = 1'b0;
            if (state_ff == flash_cmd_pkg::S_END) begin
               unique case (op_ff)
                  `OP_WR_EN:     nxt_wel = 1'b1;
                  `OP_VOL_WR_EN: nxt_vwel = 1'b1;
                  `OP_ENTER_4B:  nxt_bank[`BANK_MODE_BIT] = 1'b1;
                  `OP_EXIT_4B:   nxt_bank[`BANK_MODE_BIT] = 1'b0;
                  `OP_RST_EN:    nxt_rsten = 1'b1;
                  `OP_RST: begin
                     if (rsten_ff) begin
                        nxt_srst = 1'b1;
                        nxt_bank = `BANK_RESET;
                        nxt_wel  = 1'b0;
                        nxt_vwel = 1'b0;
                        nxt_vact = 1'b0;
                     end
                  end
                  default: ;
               endcase
            end else if (state_ff == flash_cmd_pkg::S_DIN && nb_ff == 2'h1)
            begin
               if (op_ff == `OP_BANK_WR) begin
                  nxt_bank = data_ff;
               end else if (vwel_ff) begin
                  nxt_stat_vol = data_ff;
                  nxt_vact     = 1'b1;
                  nxt_vwel     = 1'b0;
               end else if (wel_ff) begin
                  nxt_stat_nv = data_ff;
                  nxt_wel     = 1'b0;
               end
            end
         end
      end else if (pins.sck_rise) begin
         if (state_ff == flash_cmd_pkg::S_IDLE) begin
            nxt_state = flash_cmd_pkg::S_CMD;
         end
         nxt_sh  = shin;
         nxt_cnt = byte_done ? 4'h0 : cnt_ff + wid;
         if (byte_done) begin
            unique case (state_ff)
               flash_cmd_pkg::S_IDLE, flash_cmd_pkg::S_CMD: begin
                  nxt_op = shin;
                  unique case (shin)
                     `OP_WR_EN, `OP_VOL_WR_EN, `OP_ENTER_4B,
                     `OP_EXIT_4B, `OP_RST_EN, `OP_RST:
                        nxt_state = flash_cmd_pkg::S_END;
                     `OP_BANK_RD: begin
                        nxt_out   = bank_ff;
                        nxt_state = flash_cmd_pkg::S_DOUT;
                     end
                     `OP_STAT_RD: begin
                        nxt_out = stat_act;
                        nxt_out[`STAT_WEL_BIT] = wel_ff;
                        nxt_state = flash_cmd_pkg::S_DOUT;
                     end
                     `OP_BANK_WR, `OP_STAT_WR: begin
                        nxt_nb    = 2'h0;
                        nxt_state = flash_cmd_pkg::S_DIN;
                     end
                     `OP_READ: begin
                        nxt_a4     = bank_ff[`BANK_MODE_BIT];
                        nxt_abytes = bank_ff[`BANK_MODE_BIT] ? 3'h4 : 3'h3;
                        nxt_state  = flash_cmd_pkg::S_ADDR;
                     end
                     `OP_READ_4B: begin
                        nxt_a4     = 1'b1;
                        nxt_abytes = 3'h4;
                        nxt_state  = flash_cmd_pkg::S_ADDR;
                     end
                     default: nxt_state = flash_cmd_pkg::S_SKIP;
                  endcase
               end
               flash_cmd_pkg::S_ADDR: begin
                  nxt_asr    = {asr_ff[15:0], shin};
                  nxt_abytes = abytes_ff - 3'h1;
                  if (abytes_ff == 3'h1) begin
                     nxt_stb   = 1'b1;
                     nxt_state = flash_cmd_pkg::S_SKIP;
                     if (a4_ff) begin
                        nxt_addr = {asr_ff, shin};
                     end else begin
                        nxt_addr = {1'b0, bank_ff[6:0],
                                    asr_ff[15:0], shin};
                     end
                  end
               end
               flash_cmd_pkg::S_DIN: begin
                  nxt_data = shin;
                  nxt_nb   = (nb_ff == 2'h2) ? 2'h2 : nb_ff + 2'h1;
               end
               flash_cmd_pkg::S_END: nxt_state = flash_cmd_pkg::S_SKIP;
               default: ;
            endcase
         end
      end else if (pins.sck_fall && state_ff == flash_cmd_pkg::S_DOUT) begin
         // The byte rotates so a long read repeats it.
         unique case (pins.lanes)
            `LANES_ONE: begin
               nxt_io  = {2'h0, out_ff[7], 1'b0};
               nxt_oe  = 4'h2;
               nxt_out = {out_ff[6:0], out_ff[7]};
            end
            `LANES_TWO: begin
               nxt_io  = {2'h0, out_ff[7:6]};
               nxt_oe  = 4'h3;
               nxt_out = {out_ff[5:0], out_ff[7:6]};
            end
            default: begin
               nxt_io  = out_ff[7:4];
               nxt_oe  = 4'hF;
               nxt_out = {out_ff[3:0], out_ff[7:4]};
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         state_ff    <= flash_cmd_pkg::S_IDLE;
         sh_ff       <= 8'h00;
         out_ff      <= 8'h00;
         op_ff       <= 8'h00;
         data_ff     <= 8'h00;
         bank_ff     <= `BANK_RESET;
         stat_nv_ff  <= `STAT_RESET;
         stat_vol_ff <= `STAT_RESET;
         asr_ff      <= 24'h000000;
         addr_ff     <= 32'h00000000;
         cnt_ff      <= 4'h0;
         io_ff       <= 4'h0;
         oe_ff       <= 4'h0;
         abytes_ff   <= 3'h0;
         nb_ff       <= 2'h0;
         a4_ff       <= 1'b0;
         wel_ff      <= 1'b0;
         vwel_ff     <= 1'b0;
         vact_ff     <= 1'b0;
         rsten_ff    <= 1'b0;
         stb_ff      <= 1'b0;
         srst_ff     <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         sh_ff       <= nxt_sh;
         out_ff      <= nxt_out;
         op_ff       <= nxt_op;
         data_ff     <= nxt_data;
         bank_ff     <= nxt_bank;
         stat_nv_ff  <= nxt_stat_nv;
         stat_vol_ff <= nxt_stat_vol;
         asr_ff      <= nxt_asr;
         addr_ff     <= nxt_addr;
         cnt_ff      <= nxt_cnt;
         io_ff       <= nxt_io;
         oe_ff       <= nxt_oe;
         abytes_ff   <= nxt_abytes;
         nb_ff       <= nxt_nb;
         a4_ff       <= nxt_a4;
         wel_ff      <= nxt_wel;
         vwel_ff     <= nxt_vwel;
         vact_ff     <= nxt_vact;
         rsten_ff    <= nxt_rsten;
         stb_ff      <= nxt_stb;
         srst_ff     <= nxt_srst;
      end
   end

   logic [7:0] caps_ff;

   always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         caps_ff <= 8'h00;
      end else begin
         caps_ff <= `CAPS_WORD;
      end
   end

   assign SPI_IO_OUT     = io_ff;
   assign SPI_IO_OE_OUT  = oe_ff;
   assign ADDR_OUT       = addr_ff;
   assign ADDR_STB_OUT   = stb_ff;
   assign BANK_OUT       = bank_ff;
   assign STATUS_OUT     = stat_nv_ff;
   assign STATUS_VOL_OUT = vact_ff;
   assign WEL_OUT        = wel_ff;
   assign SOFT_RST_OUT   = srst_ff;
   assign CAPS_OUT       = caps_ff;

   logic fin;
   assign fin = pins.cs_rise;

   bank_write_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!NRST_IN) fin && state_ff == flash_cmd_pkg::S_DIN
      && op_ff == `OP_BANK_WR && nb_ff == 2'h1 |=> BANK_OUT == $past(data_ff))
      else $error("Bank write did not take the data byte.");
   enter_mode_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!NRST_IN) fin && state_ff == flash_cmd_pkg::S_END
      && op_ff == `OP_ENTER_4B |=> BANK_OUT[`BANK_MODE_BIT])
      else $error("Entry opcode left 3-byte mode set.");
   exit_mode_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!NRST_IN) fin && state_ff == flash_cmd_pkg::S_END
      && op_ff == `OP_EXIT_4B |=> !BANK_OUT[`BANK_MODE_BIT])
      else $error("Exit opcode left 4-byte mode set.");
   reset_pair_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!NRST_IN) SOFT_RST_OUT |-> $past(rsten_ff)
      && $past(op_ff) == `OP_RST && BANK_OUT == `BANK_RESET && !WEL_OUT)
      else $error("Soft reset without the enable pair.");
   nv_guard_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!NRST_IN)
      $changed(STATUS_OUT) |-> $past(wel_ff) && !$past(vwel_ff))
      else $error("Stored status changed without write enable.");
   vol_copy_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!NRST_IN)
      $rose(STATUS_VOL_OUT) |-> $past(vwel_ff) && !vwel_ff)
      else $error("Volatile status activated without 50h.");
   bank_addr_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!NRST_IN)
      ADDR_STB_OUT && !a4_ff |-> ADDR_OUT[31:24] == {1'b0, bank_ff[6:0]})
      else $error("3-byte address lost the bank bits.");
   mode_pick_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!NRST_IN) pins.sck_rise && byte_done
      && state_ff == flash_cmd_pkg::S_CMD && shin == `OP_READ
      |=> a4_ff == $past(bank_ff[`BANK_MODE_BIT]))
      else $error("Address width ignored the mode bit.");
   ded_read_a: assert property (@(posedge REF_CLK_IN)
      disable iff (!NRST_IN) pins.sck_rise && byte_done
      && state_ff == flash_cmd_pkg::S_CMD && shin == `OP_READ_4B
      |=> a4_ff && abytes_ff == 3'h4)
      else $error("Dedicated read did not take four bytes.");

endmodule // flash_cmd

// [flash_cmd_defines.svh]
// Opcodes, field positions, reset values and encodings of the command block.
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

`define OP_WR_EN      8'h06
`define OP_VOL_WR_EN  8'h50
`define OP_BANK_RD    8'h16
`define OP_BANK_WR    8'h17
`define OP_ENTER_4B   8'hB7
`define OP_EXIT_4B    8'hE9
`define OP_RST_EN     8'h66
`define OP_RST        8'h99
`define OP_STAT_RD    8'h05
`define OP_STAT_WR    8'h01
`define OP_READ       8'h03
`define OP_READ_4B    8'h13

`define BANK_MODE_BIT 7
`define BANK_RESET    8'h00
`define STAT_RESET    8'h00
`define STAT_WEL_BIT  1

`define LANES_ONE     2'h0
`define LANES_TWO     2'h1
`define LANES_FOUR    2'h2

// Supported features read as one: 4-byte entry, exit, bank, reset, 4B set.
`define CAPS_WORD     8'h1F

`endif

// [flash_cmd_pkg.sv]
// Types shared by the command block and its pin front end.
package flash_cmd_pkg;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_CMD  = 3'h1,
      S_ADDR = 3'h2,
      S_DIN  = 3'h3,
      S_DOUT = 3'h4,
      S_END  = 3'h5,
      S_SKIP = 3'h6
   } state_t;

   typedef struct packed {
      logic       cs_n;
      logic       cs_rise;
      logic       sck_rise;
      logic       sck_fall;
      logic [3:0] io;
      logic [1:0] lanes;
   } pins_t;

endpackage : flash_cmd_pkg

// [pin_sampler.sv]
// Two-stage synchronisers and edge finders for the serial pins.
module pin_sampler (
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_n_in,
   // Raw pins
   input  wire logic                 cs_n_in,
   input  wire logic                 sck_in,
   input  wire logic [3:0]           io_in,
   input  wire logic [1:0]           lanes_in,
   // Sampled view
   output flash_cmd_pkg::pins_t      pins_out
);

   logic [7:0] raw;
   logic [7:0] s1_ff;
   logic [7:0] s2_ff;
   logic [1:0] s3_ff;

   assign raw = {cs_n_in, sck_in, io_in, lanes_in};

   // Chip select idles high so the block starts deselected.
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_sync
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               s1_ff[g] <= (g == 7) ? 1'b1 : 1'b0;
               s2_ff[g] <= (g == 7) ? 1'b1 : 1'b0;
            end else begin
               s1_ff[g] <= raw[g];
               s2_ff[g] <= s1_ff[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s3_ff <= 2'h2;
      end else begin
         s3_ff <= s2_ff[7:6];
      end
   end

   always_comb begin
      pins_out.cs_n     = s2_ff[7];
      pins_out.cs_rise  = s2_ff[7] & ~s3_ff[1];
      pins_out.sck_rise = s2_ff[6] & ~s3_ff[0];
      pins_out.sck_fall = ~s2_ff[6] & s3_ff[0];
      pins_out.io       = s2_ff[5:2];
      pins_out.lanes    = s2_ff[1:0];
   end

endmodule // pin_sampler

// [spi_host_model.sv]
// Host controller model that sends framed instructions over the serial link.
module spi_host_model (
   // Serial link towards the flash
   output logic        cs_n_out,
   output logic        sck_out,
   output logic [3:0]  io_out,
   // Resolved data lines
   input  wire logic [3:0] io_in
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam real HALF = 62.5;

   logic [7:0] rd_byte;

   initial begin
      cs_n_out = 1'b1;
      sck_out  = 1'b0;
      io_out   = 4'hA;
   end

   // The clock stands low outside frames; released lines show a changed value.
   task automatic start_frame();
      cs_n_out = 1'b0;
      #(HALF);
   endtask

   task automatic stop_frame();
      #(HALF);
      cs_n_out = 1'b1;
      io_out   = ~io_out;
      #(4 * HALF);
   endtask

   // Width 1, 2 or 4 lines, most significant bits first.
   task automatic put_byte(input logic [7:0] b, input int w);
      for (int i = 8 - w; i >= 0; i -= w) begin
         case (w)
            1:       io_out[0]   = b[i];
            2:       io_out[1:0] = b[i+:2];
            default: io_out      = b[i+:4];
         endcase
         #(HALF) sck_out = 1'b1;
         #(HALF) sck_out = 1'b0;
      end
   endtask

   // Data is taken on the rising edge; one line mode answers on the second.
   task automatic get_byte(input int w);
      for (int i = 8 - w; i >= 0; i -= w) begin
         io_out[0] = ~io_out[0];
         #(HALF) sck_out = 1'b1;
         case (w)
            1:       rd_byte[i]    = io_in[1];
            2:       rd_byte[i+:2] = io_in[1:0];
            default: rd_byte[i+:4] = io_in;
         endcase
         #(HALF) sck_out = 1'b0;
      end
   endtask

   // One instruction per frame, followed by nb whole bytes of d.
   task automatic cmd(input logic [7:0] op, input logic [31:0] d,
                      input int nb, input int w);
      start_frame();
      put_byte(op, w);
      for (int k = nb - 1; k >= 0; k--) begin
         put_byte(d[8*k+:8], w);
      end
      stop_frame();
   endtask

   task automatic rd(input logic [7:0] op, input int w,
                     output logic [7:0] v);
      start_frame();
      put_byte(op, w);
      get_byte(w);
      stop_frame();
      v = rd_byte;
   endtask
endmodule // spi_host_model

// [testbench.sv]
// Self-checking bench for the flash command interpreter.
`include "flash_cmd_defines.svh"

module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic        ref_clk;
   logic        nrst;
   logic [1:0]  lane_mode;
   wire         cs_n;
   wire         sck;
   wire  [3:0]  host_io;
   wire  [3:0]  io_wire;
   logic [3:0]  dev_io;
   logic [3:0]  dev_oe;
   logic [31:0] addr;
   logic        addr_stb;
   logic [7:0]  bank;
   logic [7:0]  status;
   logic        status_vol;
   logic        wel;
   logic        soft_rst;
   logic [7:0]  caps;
   int          error_cnt;
   int          comparisons;
   int          rst_pulses;
   int          stb_pulses;
   logic [3:0]  oe_last;

   // The device wins a line only where it enables its driver.
   assign io_wire = (dev_oe & dev_io) | (~dev_oe & host_io);

   spi_host_model host (
      .cs_n_out (cs_n),
      .sck_out  (sck),
      .io_out   (host_io),
      .io_in    (io_wire)
   );

   flash_cmd uut (
      .REF_CLK_IN     (ref_clk),
      .NRST_IN        (nrst),
      .SPI_CS_N_IN    (cs_n),
      .SPI_SCK_IN     (sck),
      .SPI_IO_IN      (io_wire),
      .SPI_IO_OUT     (dev_io),
      .SPI_IO_OE_OUT  (dev_oe),
      .LANE_MODE_IN   (lane_mode),
      .ADDR_OUT       (addr),
      .ADDR_STB_OUT   (addr_stb),
      .BANK_OUT       (bank),
      .STATUS_OUT     (status),
      .STATUS_VOL_OUT (status_vol),
      .WEL_OUT        (wel),
      .SOFT_RST_OUT   (soft_rst),
      .CAPS_OUT       (caps)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Pulses last one cycle, so they are counted at the settled falling edge.
   always @(negedge ref_clk) begin
      if (soft_rst === 1'b1) rst_pulses++;
      if (addr_stb === 1'b1) stb_pulses++;
      if (dev_oe !== 4'h0) oe_last = dev_oe;
   end

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic settle();
      repeat (10) @(negedge ref_clk);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic t_reset_values();
      chk("bank", {24'h0, `BANK_RESET}, {24'h0, bank});
      chk("status", {24'h0, `STAT_RESET}, {24'h0, status});
      chk("wel", 32'h0, {31'h0, wel});
      chk("caps", {24'h0, `CAPS_WORD}, {24'h0, caps});
      $display("test reset values done");
   endtask

   task automatic t_bank();
      logic [7:0] v;
      host.cmd(`OP_BANK_WR, 32'h35, 1, 1);
      settle();
      chk("bank", 32'h35, {24'h0, bank});
      host.rd(`OP_BANK_RD, 1, v);
      chk("bank read", 32'h35, {24'h0, v});
      host.cmd(`OP_BANK_WR, 32'h4477, 2, 1);
      settle();
      chk("bank two bytes", 32'h35, {24'h0, bank});
      $display("test bank register done");
   endtask

   task automatic t_addr();
      int s0;
      host.cmd(`OP_BANK_WR, 32'h05, 1, 1);
      s0 = stb_pulses;
      host.cmd(`OP_READ, 32'h123456, 3, 1);
      settle();
      chk("strobes", s0 + 1, stb_pulses);
      chk("addr 3b", 32'h05123456, addr);
      host.cmd(`OP_READ_4B, 32'hFEDCBA98, 4, 1);
      settle();
      chk("addr 4b set", 32'hFEDCBA98, addr);
      chk("wel", 32'h0, {31'h0, wel});
      host.cmd(`OP_ENTER_4B, 32'h0, 0, 1);
      settle();
      chk("bank 4b", 32'h85, {24'h0, bank});
      host.cmd(`OP_READ, 32'h76543210, 4, 1);
      settle();
      chk("addr 4b mode", 32'h76543210, addr);
      host.cmd(`OP_EXIT_4B, 32'h0, 0, 1);
      settle();
      chk("bank exit", 32'h05, {24'h0, bank});
      $display("test address modes done");
   endtask

   task automatic t_soft_reset();
      int p0;
      int w;
      logic [7:0] v;
      logic [3:0] oe_exp;
      for (int m = 0; m < 3; m++) begin
         @(negedge ref_clk) lane_mode = m[1:0];
         w = 1 << m;
         settle();
         host.cmd(`OP_BANK_WR, 32'h22, 1, w);
         settle();
         chk("bank before", 32'h22, {24'h0, bank});
         oe_exp = (m == 0) ? 4'h2 : (m == 1) ? 4'h3 : 4'hF;
         host.rd(`OP_BANK_RD, w, v);
         chk("bank read lanes", 32'h22, {24'h0, v});
         chk("oe lanes", {28'h0, oe_exp}, {28'h0, oe_last});
         chk("oe idle", 32'h0, {28'h0, dev_oe});
         p0 = rst_pulses;
         host.cmd(`OP_RST_EN, 32'h0, 0, w);
         host.cmd(`OP_RST, 32'h0, 0, w);
         settle();
         chk("reset pulses", p0 + 1, rst_pulses);
         chk("bank after", 32'h0, {24'h0, bank});
      end
      @(negedge ref_clk) lane_mode = 2'h0;
      settle();
      p0 = rst_pulses;
      host.cmd(`OP_RST, 32'h0, 0, 1);
      host.cmd(`OP_RST_EN, 32'h0, 0, 1);
      host.cmd(`OP_WR_EN, 32'h0, 0, 1);
      host.cmd(`OP_RST, 32'h0, 0, 1);
      settle();
      chk("lone reset", p0, rst_pulses);
      chk("wel kept", 32'h1, {31'h0, wel});
      host.cmd(`OP_RST_EN, 32'h0, 0, 1);
      host.cmd(`OP_RST, 32'h0, 0, 1);
      settle();
      chk("wel cleared", 32'h0, {31'h0, wel});
      $display("test software reset done");
   endtask

   task automatic t_status();
      logic [7:0] v;
      host.cmd(`OP_STAT_WR, 32'hA4, 1, 1);
      settle();
      chk("status no wel", 32'h0, {24'h0, status});
      host.cmd(`OP_WR_EN, 32'h0, 0, 1);
      settle();
      chk("wel set", 32'h1, {31'h0, wel});
      host.cmd(`OP_STAT_WR, 32'hA4, 1, 1);
      settle();
      chk("status written", 32'hA4, {24'h0, status});
      chk("wel after", 32'h0, {31'h0, wel});
      host.cmd(`OP_VOL_WR_EN, 32'h0, 0, 1);
      host.cmd(`OP_STAT_WR, 32'h5C, 1, 1);
      settle();
      chk("volatile on", 32'h1, {31'h0, status_vol});
      chk("nv kept", 32'hA4, {24'h0, status});
      host.rd(`OP_STAT_RD, 1, v);
      chk("status read", 32'h5C, {24'h0, v});
      $display("test status write enables done");
   endtask

   // A mid-run reset must drop the bank and the volatile copy together.
   task automatic t_hw_reset();
      host.cmd(`OP_BANK_WR, 32'h81, 1, 1);
      settle();
      chk("bank set", 32'h81, {24'h0, bank});
      nrst = 1'b0;
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      settle();
      chk("bank hw", {24'h0, `BANK_RESET}, {24'h0, bank});
      chk("volatile off", 32'h0, {31'h0, status_vol});
      chk("status hw", {24'h0, `STAT_RESET}, {24'h0, status});
      chk("caps hw", {24'h0, `CAPS_WORD}, {24'h0, caps});
      $display("test hardware reset done");
   endtask

   // A hung run is cut short here and judged as failed.
   initial begin
      repeat (80000) @(posedge ref_clk);
      error_cnt++;
      $display("wrong value watchdog expected finish seen timeout");
      report_and_stop();
   end

   initial begin
      error_cnt   = 0;
      comparisons = 0;
      rst_pulses  = 0;
      stb_pulses  = 0;
      nrst        = 1'b0;
      lane_mode   = 2'h0;
      repeat (16) @(negedge ref_clk);
      nrst = 1'b1;
      settle();
      t_reset_values();
      t_bank();
      t_addr();
      t_soft_reset();
      t_status();
      t_hw_reset();
      report_and_stop();
   end
endmodule // testbench
